// ==== hw/bus_msg_pkg.sv ====
// Package: command codes, address limits, defaults and shared structs of the message handler
package bus_msg_pkg;

  // ---------------------------------------------------------------
  // Command codes and ranges
  // ---------------------------------------------------------------
  localparam logic [7:0] UNIV_LO = 8'h10;
  localparam logic [7:0] UNIV_HI = 8'h1F;
  localparam logic [7:0] ADDR_CMD_LO = 8'h00;
  localparam logic [7:0] ADDR_CMD_HI = 8'h0F;
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_PPC = 8'h05;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_GTR = 8'h0A;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_PPU = 8'h15;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;

  // ---------------------------------------------------------------
  // Address and serial defaults
  // ---------------------------------------------------------------
  localparam logic [4:0] BUS_ADDR_MAX = 5'h1E;
  localparam logic [4:0] BUS_ADDR_RST = 5'h1C;
  localparam int SERIAL_BAUD_DEFAULT = 115200;
  localparam logic SERIAL_PARITY_DEFAULT = 1'b0;
  localparam logic [1:0] SERIAL_STOP_DEFAULT = 2'h1;
  localparam logic [7:0] PP_CFG_RST = 8'h00;

  // ---------------------------------------------------------------
  // Shared types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic atn_n;
    logic [7:0] data;
  } bus_byte_t;

  typedef struct packed {
    logic remote;
    logic lockout;
    logic serial_poll;
    logic pp_configured;
  } iface_state_t;

endpackage : bus_msg_pkg

// ==== hw/bus_msg_handler.sv ====
// Interface message handler: decodes universal and addressed bus commands
// What this block does
// - Data bytes are commands only with attention low
// - Codes 10 to 1F act always
// - Codes 00 to 0F need listener addressing
// - Device clear aborts parser, keeps settings
// - Interface clear line ends serial poll, cancels a pending poll setup and aborts parser
// - Local lockout disables the local key
// - Poll enable enters, disable leaves serial poll
// - Poll unconfigure drops parallel poll setup
// - Addressed trigger fires like external trigger
// - Configure command accepts next poll setup byte
// - Selected clear aborts parser when addressed only
// - Bus address limited to 0 through 30
// - Address survives an instrument settings reset
// - Address set by panel or remote command
// - Serial port defaults 115200, no parity, one stop
// - Device commands and acted-on codes other than go to local switch to remote
`timescale 1ns/1ns
module bus_msg_handler
  import bus_msg_pkg::*;
#(
  parameter int BAUD_DEFAULT = SERIAL_BAUD_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire bus_byte_t bus_in,
  input wire logic ifc_n,
  input wire logic listen_addressed,
  input wire logic device_cmd,
  input wire logic local_address_key,
  input wire logic settings_reset,
  input wire logic panel_addr_we,
  input wire logic [4:0] panel_addr,
  input wire logic set_bus_address_command,
  input wire logic [4:0] remote_addr,
  output iface_state_t state,
  output logic [4:0] bus_address,
  output logic [7:0] pp_config,
  output logic trigger_pulse,
  output logic parser_clear,
  output logic [31:0] serial_baud,
  output logic serial_parity,
  output logic [1:0] serial_stop
);

  // Refuse a preset that the serial block cannot use, at elaboration
  if (BAUD_DEFAULT <= 0) begin : g_bad_baud
    $error("BAUD_DEFAULT must be positive");
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic is_cmd;
  logic is_univ;
  logic is_addr;
  assign is_cmd = bus_in.valid && !bus_in.atn_n;
  assign is_univ = is_cmd && bus_in.data >= UNIV_LO && bus_in.data <= UNIV_HI;
  assign is_addr = is_cmd && bus_in.data <= ADDR_CMD_HI && listen_addressed;

  // Only implemented, acted-on codes count; unknown or unaddressed ones leave state alone
  logic cmd_known;
  assign cmd_known = (is_univ && (bus_in.data == CMD_DCL || bus_in.data == CMD_LLO ||
    bus_in.data == CMD_SPE || bus_in.data == CMD_SPD || bus_in.data == CMD_PPU)) ||
    (is_addr && (bus_in.data == CMD_GET || bus_in.data == CMD_GTL ||
    bus_in.data == CMD_GTR || bus_in.data == CMD_PPC || bus_in.data == CMD_SDC));

  iface_state_t st_r, st_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic [7:0] ppc_r, ppc_nxt;
  logic ppc_wait_r, ppc_wait_nxt;
  logic trig_r, trig_nxt;
  logic clr_r, clr_nxt;

  // ---------------------------------------------------------------
  // Next state; interface clear has top priority
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    ppc_nxt = ppc_r;
    ppc_wait_nxt = ppc_wait_r;
    trig_nxt = 1'b0;
    clr_nxt = 1'b0;
    // Remote entry on any device command from the controller
    if (device_cmd || cmd_known) begin
      st_nxt.remote = 1'b1;
    end
    // Local key only honoured when not locked out
    if (local_address_key && !st_r.lockout) begin
      st_nxt.remote = 1'b0;
    end
    // A configure byte arrives as the next data byte after the command
    if (ppc_wait_r && bus_in.valid && bus_in.atn_n) begin
      ppc_nxt = bus_in.data;
      st_nxt.pp_configured = 1'b1;
      ppc_wait_nxt = 1'b0;
    end
    if (is_univ) begin
      case (bus_in.data)
        CMD_DCL: clr_nxt = 1'b1;
        CMD_LLO: st_nxt.lockout = 1'b1;
        CMD_SPE: st_nxt.serial_poll = 1'b1;
        CMD_SPD: st_nxt.serial_poll = 1'b0;
        CMD_PPU: begin
          st_nxt.pp_configured = 1'b0;
          ppc_nxt = PP_CFG_RST;
          ppc_wait_nxt = 1'b0;
        end
        default: ;
      endcase
    end else if (is_addr) begin
      case (bus_in.data)
        CMD_GET: trig_nxt = 1'b1;
        CMD_GTL: st_nxt.remote = 1'b0;
        CMD_GTR: st_nxt.remote = 1'b1;
        CMD_PPC: ppc_wait_nxt = 1'b1;
        CMD_SDC: clr_nxt = 1'b1;
        default: ;
      endcase
    end
    if (!ifc_n) begin
      st_nxt.serial_poll = 1'b0;
      ppc_wait_nxt = 1'b0;
      clr_nxt = 1'b1;
    end
  end

  // Address: out-of-range requests are dropped, settings reset ignored
  always_comb begin
    addr_nxt = addr_r;
    if (set_bus_address_command && remote_addr <= BUS_ADDR_MAX) begin
      addr_nxt = remote_addr;
    end else if (panel_addr_we && panel_addr <= BUS_ADDR_MAX) begin
      addr_nxt = panel_addr;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      addr_r <= BUS_ADDR_RST;
      ppc_r <= PP_CFG_RST;
      ppc_wait_r <= 1'b0;
      trig_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      ppc_r <= ppc_nxt;
      ppc_wait_r <= ppc_wait_nxt;
      trig_r <= trig_nxt;
      clr_r <= clr_nxt;
    end
  end

  assign state = st_r;
  assign bus_address = addr_r;
  assign pp_config = ppc_r;
  assign trigger_pulse = trig_r;
  assign parser_clear = clr_r;
  // Fixed presets; the serial block may override from its own menu
  assign serial_baud = 32'(BAUD_DEFAULT);
  assign serial_parity = SERIAL_PARITY_DEFAULT;
  assign serial_stop = SERIAL_STOP_DEFAULT;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_trig;
    @(posedge clk) disable iff (!resetn)
      (is_addr && bus_in.data == CMD_GET) |=> trigger_pulse ##1 !trigger_pulse;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not a single pulse");

  property p_unaddr;
    @(posedge clk) disable iff (!resetn)
      (is_cmd && bus_in.data == CMD_GET && !listen_addressed) |=> !trigger_pulse;
  endproperty
  a_unaddr: assert property (p_unaddr) else $error("unaddressed trigger acted");

  property p_atn;
    @(posedge clk) disable iff (!resetn)
      (bus_in.valid && bus_in.atn_n && !ppc_wait_r && ifc_n && !device_cmd)
        |=> $stable(st_r.serial_poll) && !trigger_pulse;
  endproperty
  a_atn: assert property (p_atn) else $error("data byte acted as command");

  property p_spe;
    @(posedge clk) disable iff (!resetn)
      (is_cmd && bus_in.data == CMD_SPE && ifc_n) |=> state.serial_poll;
  endproperty
  a_spe: assert property (p_spe) else $error("serial poll not entered");

  property p_ifc;
    @(posedge clk) disable iff (!resetn)
      !ifc_n |=> !state.serial_poll && parser_clear;
  endproperty
  a_ifc: assert property (p_ifc) else $error("interface clear ignored");

  property p_ppu;
    @(posedge clk) disable iff (!resetn)
      (is_cmd && bus_in.data == CMD_PPU) |=> !state.pp_configured && pp_config == PP_CFG_RST;
  endproperty
  a_ppu: assert property (p_ppu) else $error("parallel poll not dropped");

  property p_llo;
    @(posedge clk) disable iff (!resetn)
      (state.lockout && state.remote && local_address_key && !is_addr) |=> state.remote;
  endproperty
  a_llo: assert property (p_llo) else $error("lockout bypassed");

  property p_addr;
    @(posedge clk) disable iff (!resetn)
      bus_address <= BUS_ADDR_MAX;
  endproperty
  a_addr: assert property (p_addr) else $error("address out of range");

  property p_keep;
    @(posedge clk) disable iff (!resetn)
      (settings_reset && !set_bus_address_command && !panel_addr_we) |=> $stable(bus_address);
  endproperty
  a_keep: assert property (p_keep) else $error("address lost on settings reset");

  property p_remote;
    @(posedge clk) disable iff (!resetn)
      (device_cmd && !local_address_key) |=> state.remote;
  endproperty
  a_remote: assert property (p_remote) else $error("no remote on command");

  // Unknown codes must not even flip the remote state
  property p_unknown;
    @(posedge clk) disable iff (!resetn)
      (is_cmd && !cmd_known && ifc_n && !device_cmd && !local_address_key)
        |=> $stable(state) && !parser_clear && !trigger_pulse;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code changed state");

endmodule : bus_msg_handler

// ==== test/bus_ctrl_model.sv ====
// Bus controller model: sends command and data bytes to the handler
`timescale 1ns/1ns
module bus_ctrl_model
  import bus_msg_pkg::*;
(
  input wire logic clk,
  output bus_byte_t bus_in,
  output logic listen_addressed,
  output logic ifc_n
);
  // ------------------------------------------------------------
  // Byte and line drivers
  // ------------------------------------------------------------
  // Idle bus, clear line released
  initial begin
    bus_in = {1'b0, 1'b1, 8'h00};
    listen_addressed = 1'b0;
    ifc_n = 1'b1;
  end
  // One byte for one cycle; released data shows the inverse, never a stale copy
  task send(input logic atn_n, input logic [7:0] data, input logic lsn);
    @(posedge clk);
    #1;
    bus_in = {1'b1, atn_n, data};
    listen_addressed = lsn;
    @(posedge clk);
    #1;
    bus_in = {1'b0, 1'b1, ~data};
    listen_addressed = 1'b0;
  endtask : send
  // Interface clear held for one cycle
  task clear_line;
    @(posedge clk);
    #1;
    ifc_n = 1'b0;
    @(posedge clk);
    #1;
    ifc_n = 1'b1;
  endtask : clear_line
endmodule : bus_ctrl_model

// ==== test/bus_msg_handler_test.sv ====
// Testbench: drives the message handler through its commands and checks the outputs
`timescale 1ns/1ns
module bus_msg_handler_test;
  import bus_msg_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  bus_byte_t bus_in;
  logic ifc_n, listen_addressed, device_cmd, local_address_key, settings_reset;
  logic panel_addr_we, set_bus_address_command, trigger_pulse, parser_clear;
  logic [4:0] panel_addr, remote_addr, bus_address;
  iface_state_t state;
  logic [7:0] pp_config;
  logic [31:0] serial_baud;
  logic serial_parity;
  logic [1:0] serial_stop;
  int n_fail = 0;
  int n_tests = 0;
  bus_ctrl_model m (.clk(clk), .bus_in(bus_in), .listen_addressed(listen_addressed),
    .ifc_n(ifc_n));
  bus_msg_handler dut (.clk(clk), .resetn(resetn), .bus_in(bus_in), .ifc_n(ifc_n),
    .listen_addressed(listen_addressed), .device_cmd(device_cmd),
    .local_address_key(local_address_key), .settings_reset(settings_reset),
    .panel_addr_we(panel_addr_we), .panel_addr(panel_addr),
    .set_bus_address_command(set_bus_address_command), .remote_addr(remote_addr),
    .state(state), .bus_address(bus_address), .pp_config(pp_config),
    .trigger_pulse(trigger_pulse), .parser_clear(parser_clear), .serial_baud(serial_baud),
    .serial_parity(serial_parity), .serial_stop(serial_stop));
  always #10 clk = ~clk;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task tick;
    @(posedge clk);
    #1;
  endtask : tick
  // Four-state compare so an unknown never matches
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_trigger;
    m.send(1'b0, CMD_GET, 1'b1);
    chk(trigger_pulse, 1);
    chk(state.remote, 1);
    tick;
    chk(trigger_pulse, 0);
    m.send(1'b0, CMD_GET, 1'b0);
    chk(trigger_pulse, 0);
    m.send(1'b1, CMD_GET, 1'b1);
    chk(trigger_pulse, 0);
  endtask : t_trigger
  task t_local;
    m.send(1'b0, CMD_GTL, 1'b1);
    chk(state.remote, 0);
    m.send(1'b0, CMD_GTR, 1'b1);
    chk(state.remote, 1);
    local_address_key = 1'b1;
    tick;
    local_address_key = 1'b0;
    chk(state.remote, 0);
    device_cmd = 1'b1;
    tick;
    device_cmd = 1'b0;
    chk(state.remote, 1);
    m.send(1'b0, CMD_LLO, 1'b0);
    chk(state.lockout, 1);
    local_address_key = 1'b1;
    tick;
    local_address_key = 1'b0;
    chk(state.remote, 1);
  endtask : t_local
  task t_poll;
    m.send(1'b0, CMD_SPE, 1'b0);
    chk(state.serial_poll, 1);
    m.send(1'b0, CMD_SPD, 1'b0);
    chk(state.serial_poll, 0);
    m.send(1'b0, CMD_PPC, 1'b1);
    m.send(1'b1, 8'h5A, 1'b1);
    chk({state.pp_configured, pp_config}, 9'h15A);
    m.send(1'b0, CMD_PPU, 1'b0);
    chk({state.pp_configured, pp_config}, 9'h000);
    m.send(1'b0, CMD_GTL, 1'b1);
    chk(state.remote, 0);
    m.send(1'b0, 8'h1A, 1'b1);
    chk({state, parser_clear, trigger_pulse}, 6'h10);
  endtask : t_poll
  task t_clear;
    m.send(1'b0, CMD_DCL, 1'b0);
    chk({parser_clear, bus_address}, 6'h3C);
    tick;
    chk(parser_clear, 0);
    m.send(1'b0, CMD_SDC, 1'b0);
    chk(parser_clear, 0);
    m.send(1'b0, CMD_SDC, 1'b1);
    chk(parser_clear, 1);
    m.send(1'b0, CMD_SPE, 1'b0);
    chk(state.serial_poll, 1);
    m.clear_line;
    chk({parser_clear, state.serial_poll}, 2'h2);
  endtask : t_clear
  task t_addr;
    panel_addr_we = 1'b1;
    panel_addr = 5'h05;
    tick;
    panel_addr_we = 1'b0;
    chk(bus_address, 5'h05);
    set_bus_address_command = 1'b1;
    remote_addr = 5'h1E;
    tick;
    remote_addr = 5'h1F;
    tick;
    set_bus_address_command = 1'b0;
    chk(bus_address, 5'h1E);
    settings_reset = 1'b1;
    tick;
    settings_reset = 1'b0;
    chk(bus_address, 5'h1E);
  endtask : t_addr
  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    {device_cmd, local_address_key, settings_reset} = 3'h0;
    {panel_addr_we, set_bus_address_command, panel_addr, remote_addr} = 12'h000;
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk({state, bus_address, pp_config}, 17'h01C00);
    chk(serial_baud, 32'h0001C200);
    chk({serial_parity, serial_stop}, 3'h1);
    t_trigger;
    t_local;
    t_poll;
    t_clear;
    t_addr;
    close_out;
  end
  // Cuts a hang short
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    $display("FAIL %0t run did not finish in time", $time);
    close_out;
  end
endmodule : bus_msg_handler_test
